// ---- bcpp_chk.sv ----
// Concurrent checks on the ports of the codec and parallel port
`timescale 1ns/1ps

module bcpp_chk (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // Configuration
  input wire logic       char_width_select,
  input wire logic       cascade_fifo_select,
  input wire logic       rx_output_enable,
  // Transmit side
  input wire logic       tx_write_strobe,
  input wire logic [9:0] tx_parallel_word,
  input wire logic       tx_hold_full,
  input wire logic       tx_serial_out,
  input wire logic       tx_char_start,
  // Receive side
  input wire logic       rx_serial_in,
  input wire logic       rx_char_start,
  input wire logic       rx_read_strobe,
  input wire logic [9:0] rx_parallel_word,
  input wire logic       rx_word_error,
  input wire logic       rx_fifo_flag,
  input wire logic       rx_word_oe,
  input wire logic       rx_overflow
);
  typedef struct packed {
    logic [3:0] gap;
  } bcpp_chk_state_t;

  bcpp_chk_state_t st;
  bcpp_chk_state_t next_st;
  logic            avail;
  logic            take;

  // Saturates so the first character after reset always passes
  always_comb begin
    next_st = st;
    if (!rst_n) begin
      next_st.gap = 4'hF;
    end else if (tx_char_start) begin
      next_st.gap = 4'h1;
    end else if (st.gap != 4'hF) begin
      next_st.gap = st.gap + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    st <= next_st;
  end

  assign avail = rx_fifo_flag ^ cascade_fifo_select;
  assign take  = (rx_read_strobe == cascade_fifo_select) && avail && rx_word_oe;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_ctl_write_take: assert property (
    (!cascade_fifo_select && !tx_write_strobe && !tx_hold_full) |=> tx_hold_full)
    else $error("controller write not taken");
  chk_fifo_write_take: assert property (
    (cascade_fifo_select && tx_write_strobe && !tx_hold_full) ##1 !tx_hold_full
    |=> tx_hold_full)
    else $error("cascade write not taken a cycle late");
  chk_fifo_no_early: assert property (
    (cascade_fifo_select && tx_write_strobe && !$past(tx_write_strobe) && !tx_hold_full)
    |=> !tx_hold_full)
    else $error("cascade write taken too early");
  chk_narrow_spacing: assert property (
    (tx_char_start && char_width_select) |-> st.gap >= 4'hA)
    else $error("narrow characters too close");
  chk_wide_spacing: assert property (
    (tx_char_start && !char_width_select) |-> st.gap >= 4'hC)
    else $error("wide characters too close");
  chk_hold_loaded: assert property (
    tx_hold_full |-> ##[0:12] tx_char_start)
    else $error("held word not sent in time");
  chk_word_hold: assert property (
    !take |=> $stable(rx_parallel_word) && $stable(rx_word_error))
    else $error("receive word changed without a read");
  chk_inhibit_keeps: assert property (
    (!rx_word_oe && avail && $past(rst_n)) |=> avail)
    else $error("read performed while outputs disabled");
  chk_overflow_sticky: assert property (
    rx_overflow |=> rx_overflow)
    else $error("overflow flag dropped");
endmodule

// ---- bcpp_partner.sv ----
// Far end of the serial link: returns the line after a cable delay
`timescale 1ns/1ps

module bcpp_partner (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Response speed
  input  wire logic slow,
  // Line from the near end
  input  wire logic line_in,
  input  wire logic start_in,
  // Line back to the near end
  output logic      line_out,
  output logic      start_out
);
  typedef struct packed {
    logic [3:0] line_dly;
    logic [3:0] start_dly;
  } bcpp_partner_state_t;

  bcpp_partner_state_t st;
  bcpp_partner_state_t next_st;

  always_comb begin
    next_st           = st;
    next_st.line_dly  = {st.line_dly[2:0], line_in};
    next_st.start_dly = {st.start_dly[2:0], start_in};
    if (!rst_n) begin
      next_st = bcpp_partner_state_t'(8'h00);
    end
  end

  always_ff @(posedge ref_clk) begin
    st <= next_st;
  end

  // Slow link adds three cycles; must only change while in reset
  assign line_out  = slow ? st.line_dly[3] : st.line_dly[0];
  assign start_out = slow ? st.start_dly[3] : st.start_dly[0];
endmodule

// ---- block_codec_parallel_port_bench.sv ----
// Self-checking bench of the codec and parallel port
`timescale 1ns/1ps

module block_codec_parallel_port_bench;
  logic        ref_clk;
  logic        rst_n;
  logic        char_width_select;
  logic        cascade_fifo_select;
  logic        rx_output_enable;
  logic        tx_write_strobe;
  logic [9:0]  tx_parallel_word;
  logic        tx_hold_full;
  logic        tx_serial_out;
  logic        tx_char_start;
  logic        rx_serial_in;
  logic        rx_char_start;
  logic        rx_read_strobe;
  logic [9:0]  rx_parallel_word;
  logic        rx_word_error;
  logic        rx_fifo_flag;
  logic        rx_word_oe;
  logic        rx_overflow;
  logic        slow;
  int          error_cnt;
  int          checked;
  int          bit_cnt;
  logic        last_lvl;
  logic [11:0] shreg;
  logic [11:0] exp_s;
  logic [11:0] exp_q[$];
  logic [4:0]  enc4[16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                            5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic [5:0]  enc5[32] = '{6'h36, 6'h11, 6'h24, 6'h25, 6'h12, 6'h13, 6'h16, 6'h17,
                            6'h22, 6'h31, 6'h37, 6'h27, 6'h32, 6'h33, 6'h34, 6'h35,
                            6'h3E, 6'h19, 6'h29, 6'h2D, 6'h1A, 6'h1B, 6'h1E, 6'h1F,
                            6'h2A, 6'h2B, 6'h2E, 6'h2F, 6'h3A, 6'h3B, 6'h3C, 6'h3D};

  tcx_codec_port dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .char_width_select(char_width_select),
    .cascade_fifo_select(cascade_fifo_select), .rx_output_enable(rx_output_enable),
    .tx_write_strobe(tx_write_strobe), .tx_parallel_word(tx_parallel_word),
    .tx_hold_full(tx_hold_full), .tx_serial_out(tx_serial_out),
    .tx_char_start(tx_char_start), .rx_serial_in(rx_serial_in),
    .rx_char_start(rx_char_start), .rx_read_strobe(rx_read_strobe),
    .rx_parallel_word(rx_parallel_word), .rx_word_error(rx_word_error),
    .rx_fifo_flag(rx_fifo_flag), .rx_word_oe(rx_word_oe), .rx_overflow(rx_overflow));

  bcpp_partner link (
    .ref_clk(ref_clk), .rst_n(rst_n), .slow(slow), .line_in(tx_serial_out),
    .start_in(tx_char_start), .line_out(rx_serial_in), .start_out(rx_char_start));

  function automatic logic [11:0] exp_sym(input logic [9:0] d, input logic narrow);
    if (narrow) return {2'h0, enc4[d[7:4]], enc4[d[3:0]]};
    return {enc5[d[8:4]], enc5[{d[9], d[3:0]}]};
  endfunction

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (error_cnt == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic start(input logic narrow, input logic casc);
    rst_n <= 1'b0;
    char_width_select <= narrow;
    cascade_fifo_select <= casc;
    tx_write_strobe <= !casc;
    rx_read_strobe <= !casc;
    rx_output_enable <= 1'b1;
    slow <= 1'($urandom);
    exp_q.delete();
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    check(12'(rx_overflow), 12'h000);
  endtask

  task automatic put(input logic [9:0] d);
    int n;
    n = 0;
    // Let an edge pass so the strobe is never driven twice in one step
    @(posedge ref_clk);
    while (tx_hold_full !== 1'b0 && n < 40) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 40) check(12'(tx_hold_full), 12'h000);
    exp_q.push_back(exp_sym(d, char_width_select));
    // Wrong data in the strobe cycle exposes a capture one cycle early
    if (cascade_fifo_select) begin
      tx_write_strobe <= 1'b1;
      tx_parallel_word <= ~d;
      @(posedge ref_clk);
      tx_write_strobe <= 1'b0;
    end else begin
      tx_write_strobe <= 1'b0;
    end
    tx_parallel_word <= d;
    @(posedge ref_clk);
    tx_write_strobe <= !cascade_fifo_select;
    tx_parallel_word <= ~d;
  endtask

  task automatic get(input logic [9:0] d);
    int n;
    n = 0;
    while ((rx_fifo_flag ^ cascade_fifo_select) !== 1'b1 && n < 80) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 80) check(12'(rx_fifo_flag ^ cascade_fifo_select), 12'h001);
    rx_read_strobe <= cascade_fifo_select;
    @(posedge ref_clk);
    rx_read_strobe <= !cascade_fifo_select;
    @(posedge ref_clk);
    check(12'(rx_parallel_word & (char_width_select ? 10'h0FF : 10'h3FF)),
          12'(d & (char_width_select ? 10'h0FF : 10'h3FF)));
    check(12'(rx_word_error), 12'h000);
    check(12'(rx_fifo_flag ^ cascade_fifo_select), 12'h000);
  endtask

  // Undo the line coding and compare whole characters
  always @(posedge ref_clk) begin
    if (bit_cnt > 0 || tx_char_start === 1'b1) begin
      if (bit_cnt == 0) bit_cnt = char_width_select ? 10 : 12;
      shreg = {shreg[10:0], tx_serial_out ^ last_lvl};
      bit_cnt--;
      if (bit_cnt == 0) begin
        exp_s = exp_q.size() > 0 ? exp_q.pop_front() : 12'hFFF;
        check(shreg & (char_width_select ? 12'h3FF : 12'hFFF), exp_s);
      end
    end
    last_lvl = tx_serial_out;
  end

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (40000) @(posedge ref_clk);
    error_cnt++;
    final_report();
  end

  initial begin
    logic [9:0] d;
    logic [9:0] prev;
    rst_n = 1'b0;
    char_width_select = 1'b1;
    cascade_fifo_select = 1'b0;
    rx_output_enable = 1'b1;
    tx_write_strobe = 1'b1;
    tx_parallel_word = 10'h000;
    rx_read_strobe = 1'b1;
    slow = 1'b0;
    error_cnt = 0;
    checked = 0;
    bit_cnt = 0;
    last_lvl = 1'b0;
    shreg = 12'h000;
    void'($urandom(78));
    for (int m = 0; m < 4; m++) begin
      start(m[0], m[1]);
      // Every code of the active table in both halves of a word
      for (int i = 0; i < (m[0] ? 16 : 32); i++) begin
        d = m[0] ? 10'(i * 17) : {i[4], i[4:0], i[3:0]};
        put(d);
        get(d);
      end
      repeat (8) begin
        d = 10'($urandom);
        put(d);
        get(d);
      end
      prev = rx_parallel_word;
      d = 10'($urandom);
      rx_output_enable <= 1'b0;
      put(d);
      repeat (40) @(posedge ref_clk);
      rx_read_strobe <= cascade_fifo_select;
      repeat (3) @(posedge ref_clk);
      check(12'(rx_word_oe), 12'h000);
      rx_read_strobe <= !cascade_fifo_select;
      rx_output_enable <= 1'b1;
      @(posedge ref_clk);
      check(12'(rx_parallel_word), 12'(prev));
      check(12'(rx_fifo_flag ^ cascade_fifo_select), 12'h001);
      get(d);
      d = 10'($urandom);
      put(d);
      put(~d);
      repeat (60) @(posedge ref_clk);
      check(12'(rx_overflow), 12'h001);
      get(d);
    end
    final_report();
  end
endmodule

bind tcx_codec_port bcpp_chk chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .char_width_select(char_width_select),
  .cascade_fifo_select(cascade_fifo_select), .rx_output_enable(rx_output_enable),
  .tx_write_strobe(tx_write_strobe), .tx_parallel_word(tx_parallel_word),
  .tx_hold_full(tx_hold_full), .tx_serial_out(tx_serial_out),
  .tx_char_start(tx_char_start), .rx_serial_in(rx_serial_in),
  .rx_char_start(rx_char_start), .rx_read_strobe(rx_read_strobe),
  .rx_parallel_word(rx_parallel_word), .rx_word_error(rx_word_error),
  .rx_fifo_flag(rx_fifo_flag), .rx_word_oe(rx_word_oe), .rx_overflow(rx_overflow));

// ---- tcx_codec_port.sv ----
// Parallel port, serializer and deserializer around the symbol codec
`timescale 1ns/1ps

// Notes on behaviour
// - 8-bit mode: nibbles 0-3 encode to 11110, 01001, 10100, 10101; decode back.
// - Nibbles 4-7 encode to 01010, 01011, 01110, 01111; decode inverts.
// - Nibbles 8-B encode to 10010, 10011, 10110, 10111; decode inverts.
// - Nibbles C-F encode to 11010, 11011, 11100, 11101; decode inverts.
// - 10-bit mode: groups 00-03 encode to 110110, 010001, 100100, 100101.
// - Groups 04-07 encode to 010010, 010011, 010110, 010111; decode inverts.
// - Groups 08-0B encode to 100010, 110001, 110111, 100111; decode inverts.
// - Groups 0C-0F encode to 110010, 110011, 110100, 110101; decode inverts.
// - Groups 10-13 encode to 111110, 011001, 101001, 101101; decode inverts.
// - Groups 14-17 encode to 011010, 011011, 011110, 011111; decode inverts.
// - Groups 18-1B encode to 101010, 101011, 101110, 101111; decode inverts.
// - Groups 1C-1F encode to 111010, 111011, 111100, 111101; decode inverts.
// - Cascade mode: data taken the cycle after write strobe is sampled high.
// - Controller mode: data taken in the cycle write strobe is sampled low.
// - Cascade mode: character presented in the cycle read strobe is high.
// - Cascade mode: flag low while received data is available.
// - Controller mode: character output each cycle read strobe is low.
// - Controller mode: flag high when data available, low when empty.
// - Outputs hold previous values on inhibited reads or when empty.
// - No receive reads while the parallel outputs are disabled.
// - A character lasts 10 bit times in 8-bit mode, 12 in 10-bit mode.
// - Serial line is NRZI: one toggles the level, zero holds it.
// - Symbols shift out leftmost bit of the first symbol first.
// - 8-bit mode: bits 7..4 form the first nibble, 3..0 the second.
// - 10-bit mode: bits 8..4 first group, bits 9,3..0 second group.
module tcx_codec_port (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Configuration
  input  wire logic       char_width_select,
  input  wire logic       cascade_fifo_select,
  input  wire logic       rx_output_enable,
  // Transmit parallel side
  input  wire logic       tx_write_strobe,
  input  wire logic [9:0] tx_parallel_word,
  output logic            tx_hold_full,
  // Transmit serial side
  output logic            tx_serial_out,
  output logic            tx_char_start,
  // Receive serial side
  input  wire logic       rx_serial_in,
  input  wire logic       rx_char_start,
  // Receive parallel side
  input  wire logic       rx_read_strobe,
  output logic      [9:0] rx_parallel_word,
  output logic            rx_word_error,
  output logic            rx_fifo_flag,
  output logic            rx_word_oe,
  output logic            rx_overflow
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic                  tx_stb_d;
    logic [9:0]            tx_hold;
    logic                  tx_hold_valid;
    tcx_pkg::tcx_tx_state_t tx_state;
    logic [11:0]           tx_shift;
    logic [3:0]            tx_count;
    logic                  tx_line;
    logic                  tx_start;
    logic                  ser_meta;
    logic                  ser_sync;
    logic                  sof_meta;
    logic                  sof_sync;
    logic                  rx_prev_line;
    logic [11:0]           rx_shift;
    logic [3:0]            rx_count;
    logic                  rx_active;
    logic [9:0]            rx_buf;
    logic                  rx_buf_err;
    logic                  rx_avail;
    logic [9:0]            rx_word;
    logic                  rx_err;
    logic                  rx_flag;
    logic                  rx_oe;
    logic                  rx_ovf;
  } tcx_port_state_t;

  tcx_port_state_t st;
  tcx_port_state_t next_st;

  logic [11:0] enc_symbol;
  logic [11:0] dec_symbol;
  logic [9:0]  dec_word;
  logic        dec_error;
  logic [3:0]  char_bits;

  // ****************************************************************
  // Codec
  // ****************************************************************
  tcx_symbol_codec u_codec (
    .narrow_mode (char_width_select),
    .enc_word    (st.tx_hold),
    .enc_symbol  (enc_symbol),
    .dec_symbol  (dec_symbol),
    .dec_word    (dec_word),
    .dec_error   (dec_error)
  );

  assign char_bits = char_width_select ? tcx_pkg::CHAR_BITS_NARROW
                                       : tcx_pkg::CHAR_BITS_WIDE;

  // ****************************************************************
  // Decoder input
  // ****************************************************************
  // Narrow characters fill only the low ten bits of the shifter
  always_comb begin
    if (char_width_select) begin
      dec_symbol = {st.rx_shift[9:0], 2'h0};
    end else begin
      dec_symbol = st.rx_shift;
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic        write_now;
    logic        load_now;
    logic        rx_bit;
    logic        char_done;
    logic        read_now;
    next_st   = st;
    write_now = 1'b0;
    load_now  = 1'b0;
    rx_bit    = 1'b0;
    char_done = 1'b0;
    read_now  = 1'b0;

    // ****************************************************************
    // Transmit capture
    // ****************************************************************
    next_st.tx_stb_d = tx_write_strobe;
    if (cascade_fifo_select) begin
      write_now = st.tx_stb_d;
    end else begin
      write_now = ~tx_write_strobe;
    end

    // ****************************************************************
    // Serializer
    // ****************************************************************
    next_st.tx_start = 1'b0;
    case (st.tx_state)
      tcx_pkg::TCX_TX_IDLE: begin
        load_now = st.tx_hold_valid;
      end
      tcx_pkg::TCX_TX_SHIFT: begin
        if (st.tx_count == char_bits) begin
          load_now = st.tx_hold_valid;
          if (!st.tx_hold_valid) begin
            next_st.tx_state = tcx_pkg::TCX_TX_IDLE;
          end
        end else begin
          next_st.tx_line  = st.tx_line ^ st.tx_shift[11];
          next_st.tx_shift = {st.tx_shift[10:0], 1'b0};
          next_st.tx_count = st.tx_count + tcx_pkg::COUNT_FIRST;
        end
      end
      default: begin
        next_st.tx_state = tcx_pkg::TCX_TX_IDLE;
      end
    endcase
    if (load_now) begin
      // First bit leaves in the loading cycle, so characters abut
      next_st.tx_state = tcx_pkg::TCX_TX_SHIFT;
      next_st.tx_line  = st.tx_line ^ enc_symbol[11];
      next_st.tx_shift = {enc_symbol[10:0], 1'b0};
      next_st.tx_count = tcx_pkg::COUNT_FIRST;
      next_st.tx_start = 1'b1;
    end

    // ****************************************************************
    // Holding word
    // ****************************************************************
    // A refill may coincide with the load that empties it
    if (load_now) begin
      next_st.tx_hold_valid = 1'b0;
    end
    if (write_now && (!st.tx_hold_valid || load_now)) begin
      next_st.tx_hold       = tx_parallel_word;
      next_st.tx_hold_valid = 1'b1;
    end

    // ****************************************************************
    // Receive line synchronisers
    // ****************************************************************
    next_st.ser_meta = rx_serial_in;
    next_st.ser_sync = st.ser_meta;
    next_st.sof_meta = rx_char_start;
    next_st.sof_sync = st.sof_meta;

    // ****************************************************************
    // NRZI back to NRZ
    // ****************************************************************
    rx_bit = st.ser_sync ^ st.rx_prev_line;
    next_st.rx_prev_line = st.ser_sync;

    // ****************************************************************
    // Deframing
    // ****************************************************************
    // Completed character is decoded before the next one overwrites it
    char_done = st.rx_active && (st.rx_count == char_bits);
    if (char_done) begin
      next_st.rx_active = 1'b0;
      next_st.rx_count  = tcx_pkg::COUNT_ZERO;
    end
    if (st.sof_sync) begin
      next_st.rx_active = 1'b1;
      next_st.rx_shift  = {11'h000, rx_bit};
      next_st.rx_count  = tcx_pkg::COUNT_FIRST;
    end else if (st.rx_active && !char_done) begin
      next_st.rx_shift = {st.rx_shift[10:0], rx_bit};
      next_st.rx_count = st.rx_count + tcx_pkg::COUNT_FIRST;
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    next_st.rx_oe = rx_output_enable;
    if (cascade_fifo_select) begin
      read_now = rx_read_strobe;
    end else begin
      read_now = ~rx_read_strobe;
    end
    read_now = read_now && st.rx_avail && st.rx_oe;
    if (read_now) begin
      next_st.rx_word  = st.rx_buf;
      next_st.rx_err   = st.rx_buf_err;
      next_st.rx_avail = 1'b0;
    end
    // Otherwise the outputs keep their last character

    // ****************************************************************
    // Receive buffer
    // ****************************************************************
    // A new character wins a slot freed in the same cycle
    if (char_done) begin
      if (!st.rx_avail || read_now) begin
        next_st.rx_buf     = dec_word;
        next_st.rx_buf_err = dec_error;
        next_st.rx_avail   = 1'b1;
      end else begin
        next_st.rx_ovf = 1'b1;
      end
    end

    // ****************************************************************
    // Empty flag
    // ****************************************************************
    // Built from the next buffer state, so it never lags a read
    if (cascade_fifo_select) begin
      next_st.rx_flag = ~next_st.rx_avail;
    end else begin
      next_st.rx_flag = next_st.rx_avail;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st               <= '0;
      st.tx_hold       <= tcx_pkg::WORD_RESET;
      st.tx_state      <= tcx_pkg::TCX_TX_IDLE;
      st.tx_shift      <= tcx_pkg::SYMBOL_RESET;
      st.tx_count      <= tcx_pkg::COUNT_ZERO;
      st.tx_line       <= tcx_pkg::LINE_RESET;
      st.rx_shift      <= tcx_pkg::SYMBOL_RESET;
      st.rx_count      <= tcx_pkg::COUNT_ZERO;
      st.rx_buf        <= tcx_pkg::WORD_RESET;
      st.rx_word       <= tcx_pkg::WORD_RESET;
      // Flag reads empty in whichever polarity the mode uses
      st.rx_flag       <= cascade_fifo_select;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign tx_hold_full     = st.tx_hold_valid;
  assign tx_serial_out    = st.tx_line;
  assign tx_char_start    = st.tx_start;
  assign rx_parallel_word = st.rx_word;
  assign rx_word_error    = st.rx_err;
  assign rx_fifo_flag     = st.rx_flag;
  assign rx_word_oe       = st.rx_oe;
  assign rx_overflow      = st.rx_ovf;

endmodule

// ---- tcx_pkg.sv ----
// Shared constants and types of the nibble line codec and parallel port
package tcx_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned WORD_W   = 10;
  localparam int unsigned SYMBOL_W = 12;
  localparam int unsigned COUNT_W  = 4;

  // ****************************************************************
  // Character lengths in bit times and bit counter values
  // ****************************************************************
  localparam logic [3:0] CHAR_BITS_NARROW = 4'hA;
  localparam logic [3:0] CHAR_BITS_WIDE   = 4'hC;
  localparam logic [3:0] COUNT_ZERO       = 4'h0;
  localparam logic [3:0] COUNT_FIRST      = 4'h1;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [9:0]  WORD_RESET   = 10'h000;
  localparam logic [11:0] SYMBOL_RESET = 12'h000;
  localparam logic        LINE_RESET   = 1'b0;

  // ****************************************************************
  // Serializer states
  // ****************************************************************
  typedef enum logic [0:0] {
    TCX_TX_IDLE,
    TCX_TX_SHIFT
  } tcx_tx_state_t;

endpackage

// ---- tcx_symbol_codec.sv ----
// Combinational 4b/5b and 5b/6b symbol encoder and decoder
`timescale 1ns/1ps

module tcx_symbol_codec (
  // Mode
  input  wire logic        narrow_mode,
  // Encoder
  input  wire logic [9:0]  enc_word,
  output logic      [11:0] enc_symbol,
  // Decoder
  input  wire logic [11:0] dec_symbol,
  output logic      [9:0]  dec_word,
  output logic             dec_error
);

  // ****************************************************************
  // Tables
  // ****************************************************************
  function automatic logic [4:0] enc4(input logic [3:0] d);
    case (d)
      4'h0: enc4 = 5'h1E;
      4'h1: enc4 = 5'h09;
      4'h2: enc4 = 5'h14;
      4'h3: enc4 = 5'h15;
      4'h4: enc4 = 5'h0A;
      4'h5: enc4 = 5'h0B;
      4'h6: enc4 = 5'h0E;
      4'h7: enc4 = 5'h0F;
      4'h8: enc4 = 5'h12;
      4'h9: enc4 = 5'h13;
      4'hA: enc4 = 5'h16;
      4'hB: enc4 = 5'h17;
      4'hC: enc4 = 5'h1A;
      4'hD: enc4 = 5'h1B;
      4'hE: enc4 = 5'h1C;
      default: enc4 = 5'h1D;
    endcase
  endfunction

  function automatic logic [5:0] enc5(input logic [4:0] d);
    case (d)
      5'h00: enc5 = 6'h36;
      5'h01: enc5 = 6'h11;
      5'h02: enc5 = 6'h24;
      5'h03: enc5 = 6'h25;
      5'h04: enc5 = 6'h12;
      5'h05: enc5 = 6'h13;
      5'h06: enc5 = 6'h16;
      5'h07: enc5 = 6'h17;
      5'h08: enc5 = 6'h22;
      5'h09: enc5 = 6'h31;
      5'h0A: enc5 = 6'h37;
      5'h0B: enc5 = 6'h27;
      5'h0C: enc5 = 6'h32;
      5'h0D: enc5 = 6'h33;
      5'h0E: enc5 = 6'h34;
      5'h0F: enc5 = 6'h35;
      5'h10: enc5 = 6'h3E;
      5'h11: enc5 = 6'h19;
      5'h12: enc5 = 6'h29;
      5'h13: enc5 = 6'h2D;
      5'h14: enc5 = 6'h1A;
      5'h15: enc5 = 6'h1B;
      5'h16: enc5 = 6'h1E;
      5'h17: enc5 = 6'h1F;
      5'h18: enc5 = 6'h2A;
      5'h19: enc5 = 6'h2B;
      5'h1A: enc5 = 6'h2E;
      5'h1B: enc5 = 6'h2F;
      5'h1C: enc5 = 6'h3A;
      5'h1D: enc5 = 6'h3B;
      5'h1E: enc5 = 6'h3C;
      default: enc5 = 6'h3D;
    endcase
  endfunction

  // ****************************************************************
  // Encoding
  // ****************************************************************
  always_comb begin
    if (narrow_mode) begin
      enc_symbol = {enc4(enc_word[7:4]), enc4(enc_word[3:0]), 2'h0};
    end else begin
      enc_symbol = {enc5(enc_word[8:4]), enc5({enc_word[9], enc_word[3:0]})};
    end
  end

  // ****************************************************************
  // Decoding by searching the same tables, so both stay consistent
  // ****************************************************************
  always_comb begin
    logic       hit_hi;
    logic       hit_lo;
    logic [4:0] grp_hi;
    logic [4:0] grp_lo;
    hit_hi = 1'b0;
    hit_lo = 1'b0;
    grp_hi = 5'h00;
    grp_lo = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (narrow_mode) begin
        if (i < 16 && enc4(i[3:0]) == dec_symbol[11:7]) begin
          hit_hi = 1'b1;
          grp_hi = i[4:0];
        end
        if (i < 16 && enc4(i[3:0]) == dec_symbol[6:2]) begin
          hit_lo = 1'b1;
          grp_lo = i[4:0];
        end
      end else begin
        if (enc5(i[4:0]) == dec_symbol[11:6]) begin
          hit_hi = 1'b1;
          grp_hi = i[4:0];
        end
        if (enc5(i[4:0]) == dec_symbol[5:0]) begin
          hit_lo = 1'b1;
          grp_lo = i[4:0];
        end
      end
    end
    if (narrow_mode) begin
      dec_word = {2'h0, grp_hi[3:0], grp_lo[3:0]};
    end else begin
      dec_word = {grp_lo[4], grp_hi, grp_lo[3:0]};
    end
    dec_error = ~(hit_hi & hit_lo);
  end

endmodule
